// [design/bus_port_pkg.sv]
// constants and types for the host bus port block
package bus_port_pkg;

    // ------------------------------------------------------------
    // widths
    // ------------------------------------------------------------
    localparam int unsigned PORT_W = 8;
    localparam int unsigned ADDR_W = 20;

    // ------------------------------------------------------------
    // reset values
    // ------------------------------------------------------------
    localparam logic [19:0] ADDR_RST = 20'h00000;
    localparam logic [7:0] PORT_OUT_RST = 8'h00;
    localparam logic [2:0] PIN_MODE_RST = 3'h2;

    // ------------------------------------------------------------
    // host bus styles
    // ------------------------------------------------------------
    typedef enum logic [1:0] {
        BUS_MUX_LOW = 2'b00,
        BUS_SEPARATE = 2'b01,
        BUS_PAGE = 2'b10,
        BUS_BURST = 2'b11
    } bus_style_t;

    // ------------------------------------------------------------
    // per-pin functions of ports a and b
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        PIN_HOST_IO = 3'b000,
        PIN_MACROCELL = 3'b001,
        PIN_PLD_IN = 3'b010,
        PIN_ADDR_OUT = 3'b011,
        PIN_ADDR_IN = 3'b100,
        PIN_PERIPH = 3'b101
    } pin_mode_t;

endpackage

// [design/addr_hold_reg.sv]
// address holding register, loaded on the address phase strobe
`timescale 1ns/1ps
module addr_hold_reg (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic load,
    input wire logic [19:0] addr_in,
    output logic [19:0] addr_out
);

    logic [19:0] addr_r;
    logic [19:0] addr_nxt;

    always_comb begin
        addr_nxt = addr_r;
        if (load) begin
            addr_nxt = addr_in;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            addr_r <= bus_port_pkg::ADDR_RST;
        end else begin
            addr_r <= addr_nxt;
        end
    end

    assign addr_out = addr_r;

    hold_stable_a: assert property (@(posedge ref_clk) disable iff (srst)
        !load |=> addr_r == $past(addr_r))
        else $error("held address changed without load");

endmodule

// [design/mcu_bus_port.sv]
// host parallel bus attachment: address capture, data drive, port a/b pin functions
`timescale 1ns/1ps
//
// Contract
// - latch address on address phase strobe
// - drive data only on read with selection
// - all address bits go to logic
// - write input: write strobe or read/write
// - read input: strobe, e clock, data strobe
// - code select or general logic input
// - control inputs reach the logic
// - reset returns ports and macrocells
// - port a pin function selection
// - port a low nibble muxed high address
// - port b functions, two macrocell groups
// - low nibble push-pull, high nibble selectable
// - chip select low enables memories
module mcu_bus_port (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic reset_n,
    input wire logic [1:0] bus_style,
    input wire logic rw_is_direction,
    input wire logic e_clock_mode,
    input wire logic code_select_used,
    input wire logic addr_phase_strobe,
    input wire logic write_ctrl_input,
    input wire logic read_ctrl_input,
    input wire logic code_select_input,
    input wire logic chip_select_n,
    input wire logic [7:0] lower_addr_data_port_in,
    output logic [7:0] lower_addr_data_port_out,
    output logic [7:0] lower_addr_data_port_oe,
    input wire logic [7:0] upper_addr_data_port_in,
    output logic [7:0] upper_addr_data_port_out,
    output logic [7:0] upper_addr_data_port_oe,
    input wire logic [15:0] read_data,
    input wire logic block_selected,
    output logic [19:0] pld_addr,
    output logic pld_write,
    output logic pld_read,
    output logic pld_code_select,
    output logic pld_general_in,
    output logic memory_enable,
    output logic [15:0] write_data,
    input wire logic [23:0] port_a_mode,
    input wire logic port_a_data_bus,
    input wire logic port_a_muxed_high,
    input wire logic [7:0] port_a_host_out,
    input wire logic [7:0] port_a_periph_out,
    input wire logic [7:0] macrocell_group_one_outputs,
    input wire logic [7:0] port_a_open_drain,
    input wire logic [7:0] port_a_pins_in,
    output logic [7:0] port_a_pins_out,
    output logic [7:0] port_a_pins_oe,
    output logic [7:0] port_a_pld_in,
    input wire logic [23:0] port_b_mode,
    input wire logic [7:0] port_b_group_sel,
    input wire logic [7:0] port_b_host_out,
    input wire logic [7:0] macrocell_group_two_outputs,
    input wire logic [7:0] port_b_open_drain,
    input wire logic [7:0] port_b_pins_in,
    output logic [7:0] port_b_pins_out,
    output logic [7:0] port_b_pins_oe,
    output logic [7:0] port_b_pld_in,
    output logic [7:0] fast_slew
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [47:0] sync1_r, sync2_r, sync_nxt;
    logic [7:0] lo_s, hi_s, pa_s, pb_s;
    logic ale_s, wr_s, rd_s, cs_s, csel_s, rstn_s, rst_all;

    always_comb begin
        sync_nxt = {lower_addr_data_port_in, upper_addr_data_port_in, port_a_pins_in,
                    port_b_pins_in, addr_phase_strobe, write_ctrl_input, read_ctrl_input,
                    chip_select_n, code_select_input, reset_n, 10'h000};
    end

    always_ff @(posedge ref_clk) begin
        if (srst) begin
            sync1_r <= 48'h000000000000;
            sync2_r <= 48'h000000000000;
        end else begin
            sync1_r <= sync_nxt;
            sync2_r <= sync1_r;
        end
    end

    assign lo_s = sync2_r[47:40];
    assign hi_s = sync2_r[39:32];
    assign pa_s = sync2_r[31:24];
    assign pb_s = sync2_r[23:16];
    assign ale_s = sync2_r[15];
    assign wr_s = sync2_r[14];
    assign rd_s = sync2_r[13];
    assign cs_s = sync2_r[12];
    assign csel_s = sync2_r[11];
    assign rstn_s = sync2_r[10];
    // the pin reset acts like the core reset on ports and macrocell paths
    assign rst_all = srst || !rstn_s;

    // ------------------------------------------------------------
    // address assembly per host bus style
    // ------------------------------------------------------------
    logic [19:0] addr_in, addr_held;
    logic ale_prev_r, ale_prev_nxt, ale_rise;

    always_comb begin
        unique case (bus_port_pkg::bus_style_t'(bus_style))
            bus_port_pkg::BUS_MUX_LOW: addr_in = {4'h0, hi_s, lo_s};
            bus_port_pkg::BUS_SEPARATE: addr_in = {4'h0, hi_s, lo_s};
            bus_port_pkg::BUS_PAGE: addr_in = {4'h0, hi_s, lo_s};
            bus_port_pkg::BUS_BURST: addr_in = {hi_s, lo_s, pa_s[3:0]};
        endcase
        if (port_a_muxed_high) begin
            addr_in[19:16] = pa_s[3:0];
        end
    end

    always_comb begin
        ale_prev_nxt = ale_s;
    end

    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            ale_prev_r <= 1'b0;
        end else begin
            ale_prev_r <= ale_prev_nxt;
        end
    end

    // capture on the falling edge of the strobe, when the address is settled
    assign ale_rise = ale_prev_r && !ale_s;

    addr_hold_reg u_addr (
        .ref_clk(ref_clk),
        .srst(rst_all),
        .load(ale_rise),
        .addr_in(addr_in),
        .addr_out(addr_held)
    );

    assign pld_addr = addr_held;

    // ------------------------------------------------------------
    // control inputs into the logic
    // ------------------------------------------------------------
    logic rd_active, wr_active;

    always_comb begin
        if (rw_is_direction) begin
            wr_active = !wr_s && (e_clock_mode ? rd_s : !rd_s);
            rd_active = wr_s && (e_clock_mode ? rd_s : !rd_s);
        end else begin
            wr_active = !wr_s;
            rd_active = !rd_s;
        end
    end

    assign pld_write = wr_active;
    assign pld_read = rd_active;
    assign pld_code_select = code_select_used && !csel_s;
    assign pld_general_in = csel_s;
    assign memory_enable = !cs_s;

    // ------------------------------------------------------------
    // data drive on the address/data ports
    // ------------------------------------------------------------
    logic [15:0] dout_r, dout_nxt, wdata_r, wdata_nxt;
    logic drive_r, drive_nxt;

    always_comb begin
        drive_nxt = rd_active && block_selected && !cs_s;
        dout_nxt = read_data;
        wdata_nxt = wdata_r;
        if (wr_active) begin
            wdata_nxt = port_a_data_bus ? {hi_s, pa_s} : {hi_s, lo_s};
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            drive_r <= 1'b0;
            dout_r <= 16'h0000;
            wdata_r <= 16'h0000;
        end else begin
            drive_r <= drive_nxt;
            dout_r <= dout_nxt;
            wdata_r <= wdata_nxt;
        end
    end

    assign write_data = wdata_r;
    assign lower_addr_data_port_out = dout_r[7:0];
    assign upper_addr_data_port_out = dout_r[15:8];
    assign lower_addr_data_port_oe = {8{drive_r}};
    assign upper_addr_data_port_oe = {8{drive_r}};

    // ------------------------------------------------------------
    // port a and port b pin functions
    // ------------------------------------------------------------
    logic [7:0] pa_out_r, pa_out_nxt, pa_drv_r, pa_drv_nxt;
    logic [7:0] pb_out_r, pb_out_nxt, pb_drv_r, pb_drv_nxt;
    logic [15:0] addr_out_bits;
    assign addr_out_bits = addr_held[15:0];

    for (genvar i = 0; i < 8; i++) begin : g_pin
        logic a_val, b_val, a_en, b_en;
        always_comb begin
            a_val = 1'b0;
            a_en = 1'b0;
            unique case (bus_port_pkg::pin_mode_t'(port_a_mode[3*i +: 3]))
                bus_port_pkg::PIN_HOST_IO: begin
                    a_val = port_a_host_out[i];
                    a_en = 1'b1;
                end
                bus_port_pkg::PIN_MACROCELL: begin
                    a_val = macrocell_group_one_outputs[i];
                    a_en = 1'b1;
                end
                bus_port_pkg::PIN_ADDR_OUT: begin
                    a_val = addr_out_bits[i];
                    a_en = 1'b1;
                end
                bus_port_pkg::PIN_PERIPH: begin
                    a_val = port_a_periph_out[i];
                    a_en = rd_active && block_selected;
                end
                default: begin
                    a_val = 1'b0;
                    a_en = 1'b0;
                end
            endcase
            if (port_a_data_bus || (port_a_muxed_high && i < 4)) begin
                a_en = 1'b0;
            end
            if (i >= 4 && port_a_open_drain[i]) begin
                a_en = a_en && !a_val;
            end
            pa_out_nxt[i] = (i >= 4 && port_a_open_drain[i]) ? 1'b0 : a_val;
            pa_drv_nxt[i] = a_en;
        end
        always_comb begin
            b_val = 1'b0;
            b_en = 1'b0;
            unique case (bus_port_pkg::pin_mode_t'(port_b_mode[3*i +: 3]))
                bus_port_pkg::PIN_HOST_IO: begin
                    b_val = port_b_host_out[i];
                    b_en = 1'b1;
                end
                bus_port_pkg::PIN_MACROCELL: begin
                    b_val = port_b_group_sel[i] ? macrocell_group_two_outputs[i]
                                                : macrocell_group_one_outputs[i];
                    b_en = 1'b1;
                end
                bus_port_pkg::PIN_ADDR_OUT: begin
                    b_val = addr_out_bits[i + 8];
                    b_en = 1'b1;
                end
                default: begin
                    b_val = 1'b0;
                    b_en = 1'b0;
                end
            endcase
            if (i >= 4 && port_b_open_drain[i]) begin
                b_en = b_en && !b_val;
            end
            pb_out_nxt[i] = (i >= 4 && port_b_open_drain[i]) ? 1'b0 : b_val;
            pb_drv_nxt[i] = b_en;
        end
    end

    always_ff @(posedge ref_clk) begin
        if (rst_all) begin
            pa_out_r <= bus_port_pkg::PORT_OUT_RST;
            pa_drv_r <= 8'h00;
            pb_out_r <= bus_port_pkg::PORT_OUT_RST;
            pb_drv_r <= 8'h00;
        end else begin
            pa_out_r <= pa_out_nxt;
            pa_drv_r <= pa_drv_nxt;
            pb_out_r <= pb_out_nxt;
            pb_drv_r <= pb_drv_nxt;
        end
    end

    assign port_a_pins_out = pa_out_r;
    assign port_a_pins_oe = pa_drv_r;
    assign port_b_pins_out = pb_out_r;
    assign port_b_pins_oe = pb_drv_r;
    assign port_a_pld_in = pa_s;
    assign port_b_pld_in = pb_s;
    // fast slew on the low four bits only, from the mode low bit of pins 0 and 1 of port a and port b
    assign fast_slew = {4'h0, port_a_mode[0], port_a_mode[3], port_b_mode[0],
                        port_b_mode[3]};

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    drive_needs_read_a: assert property (@(posedge ref_clk) disable iff (rst_all)
        lower_addr_data_port_oe[0] |-> $past(rd_active) && $past(block_selected))
        else $error("data port driven without selected read");
    addr_capture_a: assert property (@(posedge ref_clk) disable iff (rst_all)
        ale_rise |=> pld_addr == $past(addr_in))
        else $error("address not captured on strobe");
    addr_held_a: assert property (@(posedge ref_clk) disable iff (rst_all)
        !ale_rise |=> $stable(pld_addr))
        else $error("address moved between strobes");
    od_high_a: assert property (@(posedge ref_clk) disable iff (rst_all)
        port_a_pins_oe[7] && $past(port_a_open_drain[7]) |-> !port_a_pins_out[7])
        else $error("open drain pin drove high");
    low_push_pull_a: assert property (@(posedge ref_clk) disable iff (rst_all)
        !$past(rst_all) && $past(port_a_mode[2:0]) == 3'b000 && !$past(port_a_data_bus)
        && !$past(port_a_muxed_high) |-> port_a_pins_oe[0])
        else $error("low nibble not push-pull");
    data_bus_in_a: assert property (@(posedge ref_clk) disable iff (rst_all)
        $past(port_a_data_bus) |-> port_a_pins_oe == 8'h00)
        else $error("port a driven in data bus mode");
    mem_enable_a: assert property (@(posedge ref_clk) disable iff (rst_all)
        memory_enable == !$past(chip_select_n, 2))
        else $error("memory enable wrong");
    reset_ports_a: assert property (@(posedge ref_clk)
        $past(rst_all) |-> port_a_pins_oe == 8'h00 && port_b_pins_oe == 8'h00)
        else $error("ports not reset");
    read_cover: cover property (@(posedge ref_clk) lower_addr_data_port_oe[0]);
    capture_cover: cover property (@(posedge ref_clk) ale_rise);
    burst_cover: cover property (@(posedge ref_clk) ale_rise && bus_style == 2'b11);
    od_cover: cover property (@(posedge ref_clk) port_b_pins_oe[5] && port_b_open_drain[5]);

endmodule

// [bench/host_model.sv]
// host microcontroller model driving the address/data bus and its strobes
`timescale 1ns/1ps
module host_model (
    input wire logic ref_clk,
    input wire logic [7:0] lo_out,
    input wire logic [7:0] lo_oe,
    input wire logic [7:0] hi_out,
    input wire logic [7:0] hi_oe,
    output logic [7:0] lo_wire,
    output logic [7:0] hi_wire,
    output logic strobe,
    output logic wr_n,
    output logic rd_n
);
    logic [7:0] lo_drv = 8'h00;
    logic [7:0] hi_drv = 8'h00;
    logic released = 1'b0;

    // ------------------------------------------------------------
    // pad level: the device wins on bits it drives
    // ------------------------------------------------------------
    // a released bus shows the inverse of its last value, so a stale value is never taken
    assign lo_wire = (lo_oe & lo_out) | (~lo_oe & (released ? ~lo_drv : lo_drv));
    assign hi_wire = (hi_oe & hi_out) | (~hi_oe & (released ? ~hi_drv : hi_drv));

    initial begin
        strobe = 1'b0;
        wr_n = 1'b1;
        rd_n = 1'b1;
    end

    // ------------------------------------------------------------
    // address phase: both bytes presented, strobe high then low
    // ------------------------------------------------------------
    task automatic addr_cycle(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge ref_clk);
        released <= 1'b0;
        lo_drv <= lo;
        hi_drv <= hi;
        strobe <= 1'b1;
        repeat (3) @(posedge ref_clk);
        strobe <= 1'b0;
        repeat (4) @(posedge ref_clk);
        released <= 1'b1;
    endtask

    // data phase of a write: both bytes held on the bus
    task automatic put_data(input logic [7:0] lo, input logic [7:0] hi);
        @(posedge ref_clk);
        released <= 1'b0;
        lo_drv <= lo;
        hi_drv <= hi;
    endtask

    task automatic rd(input logic v);
        @(posedge ref_clk);
        rd_n <= v;
    endtask

    task automatic wr(input logic v);
        @(posedge ref_clk);
        wr_n <= v;
    endtask
endmodule

// [bench/testbench.sv]
// self-checking bench for the host bus port block
`timescale 1ns/1ps
module testbench;
    logic ref_clk = 1'b0, srst = 1'b1, reset_n = 1'b0;
    logic [1:0] bus_style = 2'h0;
    logic rw_is_direction = 1'b0, e_clock_mode = 1'b0, code_select_used = 1'b1;
    logic strobe, wr_n, rd_n, code_select_input = 1'b1, chip_select_n = 1'b0;
    logic [7:0] lo_in, lo_out, lo_oe, hi_in, hi_out, hi_oe;
    logic [15:0] read_data = 16'hbeef, write_data;
    logic block_selected = 1'b0;
    logic [19:0] pld_addr;
    logic pld_write, pld_read, pld_code_select, pld_general_in, memory_enable;
    logic [23:0] port_a_mode = 24'h0, port_b_mode = 24'h0;
    logic port_a_data_bus = 1'b0, port_a_muxed_high = 1'b0;
    logic [7:0] pa_host = 8'h00, pa_periph = 8'h00, mc_one = 8'h00, pa_od = 8'h00;
    logic [7:0] pa_in = 8'h09, pa_out, pa_oe, pa_pld, pb_sel = 8'h00, pb_host = 8'h00;
    logic [7:0] mc_two = 8'h00, pb_od = 8'h00, pb_in = 8'h00, pb_out, pb_oe, pb_pld, slew;
    int n_mismatch = 0, n_compared = 0;

    initial forever #10 ref_clk = ~ref_clk;

    mcu_bus_port mcu_bus_port_inst (.ref_clk(ref_clk), .srst(srst), .reset_n(reset_n),
        .bus_style(bus_style), .rw_is_direction(rw_is_direction),
        .e_clock_mode(e_clock_mode), .code_select_used(code_select_used),
        .addr_phase_strobe(strobe), .write_ctrl_input(wr_n), .read_ctrl_input(rd_n),
        .code_select_input(code_select_input), .chip_select_n(chip_select_n),
        .lower_addr_data_port_in(lo_in), .lower_addr_data_port_out(lo_out),
        .lower_addr_data_port_oe(lo_oe), .upper_addr_data_port_in(hi_in),
        .upper_addr_data_port_out(hi_out), .upper_addr_data_port_oe(hi_oe),
        .read_data(read_data), .block_selected(block_selected), .pld_addr(pld_addr),
        .pld_write(pld_write), .pld_read(pld_read), .pld_code_select(pld_code_select),
        .pld_general_in(pld_general_in), .memory_enable(memory_enable),
        .write_data(write_data), .port_a_mode(port_a_mode),
        .port_a_data_bus(port_a_data_bus), .port_a_muxed_high(port_a_muxed_high),
        .port_a_host_out(pa_host), .port_a_periph_out(pa_periph),
        .macrocell_group_one_outputs(mc_one), .port_a_open_drain(pa_od),
        .port_a_pins_in(pa_in), .port_a_pins_out(pa_out), .port_a_pins_oe(pa_oe),
        .port_a_pld_in(pa_pld), .port_b_mode(port_b_mode), .port_b_group_sel(pb_sel),
        .port_b_host_out(pb_host), .macrocell_group_two_outputs(mc_two),
        .port_b_open_drain(pb_od), .port_b_pins_in(pb_in), .port_b_pins_out(pb_out),
        .port_b_pins_oe(pb_oe), .port_b_pld_in(pb_pld), .fast_slew(slew));

    host_model host_model_inst (.ref_clk(ref_clk), .lo_out(lo_out), .lo_oe(lo_oe),
        .hi_out(hi_out), .hi_oe(hi_oe), .lo_wire(lo_in), .hi_wire(hi_in),
        .strobe(strobe), .wr_n(wr_n), .rd_n(rd_n));

    // ------------------------------------------------------------
    // compare and closing report
    // ------------------------------------------------------------
    task automatic chk(input string what, input logic [19:0] exp, input logic [19:0] got);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic wrap_up();
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    task automatic t_styles();
        logic [19:0] exp;
        for (int s = 0; s < 4; s++) begin
            @(posedge ref_clk);
            bus_style <= 2'(s);
            exp = (s == 3) ? {8'h3c, 8'(8'h51 + s), 4'h9} : {4'h0, 8'h3c, 8'(8'h51 + s)};
            host_model_inst.addr_cycle(8'(8'h51 + s), 8'h3c);
            for (int i = 0; i < 12 && pld_addr !== exp; i++) @(negedge ref_clk);
            chk("pld_addr", exp, pld_addr);
            repeat (6) @(negedge ref_clk);
            chk("pld_addr held", exp, pld_addr);
        end
        @(posedge ref_clk);
        bus_style <= 2'h0;
        port_a_muxed_high <= 1'b1;
        host_model_inst.addr_cycle(8'h77, 8'h66);
        for (int i = 0; i < 12 && pld_addr !== 20'h96677; i++) @(negedge ref_clk);
        chk("pld_addr muxed high", 20'h96677, pld_addr);
        chk("port a oe muxed high", 8'hf0, pa_oe);
        @(posedge ref_clk);
        port_a_muxed_high <= 1'b0;
    endtask

    task automatic t_read();
        @(posedge ref_clk);
        bus_style <= 2'h0;
        block_selected <= 1'b1;
        host_model_inst.addr_cycle(8'h10, 8'h20);
        host_model_inst.rd(1'b0);
        for (int i = 0; i < 8 && lo_oe !== 8'hff; i++) @(negedge ref_clk);
        chk("lower oe", 8'hff, lo_oe);
        chk("lower out", 8'hef, lo_out);
        chk("upper oe", 8'hff, hi_oe);
        chk("upper out", 8'hbe, hi_out);
        chk("pld_read", 1'b1, pld_read);
        chk("memory_enable", 1'b1, memory_enable);
        host_model_inst.rd(1'b1);
        for (int i = 0; i < 8 && lo_oe !== 8'h00; i++) @(negedge ref_clk);
        chk("lower oe off", 8'h00, lo_oe);
        @(posedge ref_clk);
        block_selected <= 1'b0;
        chip_select_n <= 1'b1;
        host_model_inst.rd(1'b0);
        repeat (6) @(negedge ref_clk);
        chk("oe unselected", 8'h00, lo_oe);
        chk("memory_enable off", 1'b0, memory_enable);
        host_model_inst.rd(1'b1);
    endtask

    task automatic t_ctrl();
        @(posedge ref_clk);
        chip_select_n <= 1'b0;
        code_select_input <= 1'b0;
        host_model_inst.put_data(8'h34, 8'h12);
        host_model_inst.wr(1'b0);
        repeat (4) @(negedge ref_clk);
        chk("pld_write", 1'b1, pld_write);
        chk("write_data", 16'h1234, write_data);
        chk("pld_code_select", 1'b1, pld_code_select);
        host_model_inst.wr(1'b1);
        code_select_used <= 1'b0;
        code_select_input <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("pld_write off", 1'b0, pld_write);
        chk("pld_general_in", 1'b1, pld_general_in);
        @(posedge ref_clk);
        rw_is_direction <= 1'b1;
        e_clock_mode <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("pld_read direction", 1'b1, pld_read);
        host_model_inst.wr(1'b0);
        repeat (4) @(negedge ref_clk);
        chk("pld_write direction", 1'b1, pld_write);
        chk("pld_read on write", 1'b0, pld_read);
        host_model_inst.rd(1'b0);
        repeat (4) @(negedge ref_clk);
        chk("pld_write e low", 1'b0, pld_write);
        host_model_inst.wr(1'b1);
        host_model_inst.rd(1'b1);
        @(posedge ref_clk);
        rw_is_direction <= 1'b0;
        e_clock_mode <= 1'b0;
    endtask

    task automatic t_ports();
        @(posedge ref_clk);
        port_a_mode <= {8{bus_port_pkg::PIN_MACROCELL}};
        mc_one <= 8'h5c;
        pa_od <= 8'hf0;
        port_b_mode <= {8{bus_port_pkg::PIN_MACROCELL}};
        pb_sel <= 8'hff;
        mc_two <= 8'h3a;
        pb_in <= 8'h6b;
        repeat (4) @(negedge ref_clk);
        chk("port a out", 8'h0c, pa_out);
        chk("port a oe", 8'haf, pa_oe);
        chk("port b out", 8'h3a, pb_out);
        chk("port b oe", 8'hff, pb_oe);
        chk("fast_slew", 8'h0f, slew);
        chk("port a pld in", 8'h09, pa_pld);
        chk("port b pld in", 8'h6b, pb_pld);
        @(posedge ref_clk);
        port_a_data_bus <= 1'b1;
        repeat (4) @(negedge ref_clk);
        chk("port a oe data bus", 8'h00, pa_oe);
        @(posedge ref_clk);
        port_a_data_bus <= 1'b0;
    endtask

    task automatic t_pin_reset();
        @(posedge ref_clk);
        reset_n <= 1'b0;
        repeat (5) @(posedge ref_clk);
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk("addr after reset", 20'h00000, pld_addr);
        chk("port a oe after reset", 8'h00, pa_oe);
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        n_mismatch++;
        wrap_up();
    end

    initial begin
        repeat (4) @(posedge ref_clk);
        srst <= 1'b0;
        reset_n <= 1'b1;
        @(negedge ref_clk);
        chk("oe at reset", 8'h00, lo_oe);
        chk("addr at reset", 20'h00000, pld_addr);
        t_styles();
        t_read();
        t_ctrl();
        t_ports();
        t_pin_reset();
        wrap_up();
    end
endmodule
